// file: core/dpp_pkg.sv
// Package with the address map, field masks and reset values of the port data block
package dpp_pkg;
   // Byte addresses on the register bus
   localparam logic [31:0] DPP_ADDR_P1_DATA = 32'hFFFF8380;
   localparam logic [31:0] DPP_ADDR_P1_DIR = 32'hFFFF8384;
   localparam logic [31:0] DPP_ADDR_P2_DATA = 32'hFFFF83B0;
   localparam logic [31:0] DPP_ADDR_P2_DIR = 32'hFFFF83B4;
   localparam logic [31:0] DPP_ADDR_P2_FUNC = 32'hFFFF83B8;

   // Implemented bits of each register; everything else reads zero
   localparam logic [15:0] DPP_P1_MASK = 16'h000C;
   localparam logic [15:0] DPP_P2_MASK = 16'h70F5;
   localparam logic [15:0] DPP_P2_FUNC_MASK = 16'h00F5;
   localparam logic [15:0] DPP_NO_PINS = 16'h0000;

   // Power-on values: data cleared, every pin an input, every shared pin general I/O
   localparam logic [15:0] DPP_DATA_RESET = 16'h0000;
   localparam logic [15:0] DPP_DIR_RESET = 16'h0000;
   localparam logic [15:0] DPP_FUNC_RESET = 16'h0000;

   // Bus response codes
   localparam logic [1:0] DPP_RESP_OKAY = 2'h0;
   localparam logic [1:0] DPP_RESP_SLVERR = 2'h2;
   localparam logic [15:0] DPP_UPPER_ZERO = 16'h0000;
endpackage

// file: core/dpp_pin_bank.sv
// Pin bank: output drive, enable, input synchroniser and read-back of one port
`timescale 1ns/1ps
`default_nettype none
module dpp_pin_bank #(
   parameter logic [15:0] MASK = 16'hFFFF
) (
   input wire logic clk_sys_i, // System clock
   input wire logic reset_n_i, // Asynchronous reset, active low
   input wire logic [15:0] data_i, // Stored data bits
   input wire logic [15:0] dir_i, // Direction, 1 = output
   input wire logic [15:0] alt_i, // 1 = pin handed to the timer
   input wire logic [15:0] alt_out_i, // Timer drive value
   input wire logic [15:0] pin_in_i, // Raw pin levels
   output logic [15:0] pin_out_o, // Pin drive value
   output logic [15:0] pin_oe_n_o, // Output enable, low = driving
   output logic [15:0] level_o, // Synchronised pin levels
   output logic [15:0] read_o // Value a register read returns
);
   logic [15:0] meta_r;
   logic [15:0] sync_r;
   logic [15:0] out_r;
   logic [15:0] oe_n_r;
   wire [15:0] drive_nxt;

   // Timer owns the drive value of a handed-over pin, stored data owns the rest
   assign drive_nxt = ((alt_i & alt_out_i) | (~alt_i & data_i)) & MASK;

   // Drive and enable are registered so the pads see no decode glitches
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_r <= 16'h0000;
         oe_n_r <= 16'hFFFF;
      end else begin
         out_r <= drive_nxt;
         oe_n_r <= ~(dir_i & MASK);
      end
   end

   // Two-stage synchroniser; only the second stage is read
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_r <= 16'h0000;
         sync_r <= 16'h0000;
      end else begin
         meta_r <= pin_in_i;
         sync_r <= meta_r;
      end
   end

   // Outputs read back the stored bit, inputs the live level, alternate or not
   assign read_o = ((dir_i & data_i) | (~dir_i & sync_r)) & MASK;
   assign pin_out_o = out_r;
   assign pin_oe_n_o = oe_n_r;
   assign level_o = sync_r & MASK;

   property p_input_released;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      1'b1 |=> ((~pin_oe_n_o) & ~$past(dir_i & MASK)) == 16'h0000;
   endproperty
   a_input_released: assert property (p_input_released)
      else $error("pin driven while its direction bit is zero");

   property p_gpio_drive;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      1'b1 |=> ((pin_out_o ^ $past(data_i)) & $past(dir_i & ~alt_i & MASK)) == 16'h0000;
   endproperty
   a_gpio_drive: assert property (p_gpio_drive)
      else $error("general output pin does not show its stored bit");

   property p_alt_drive;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      1'b1 |=> ((pin_out_o ^ $past(alt_out_i)) & $past(dir_i & alt_i & MASK)) == 16'h0000;
   endproperty
   a_alt_drive: assert property (p_alt_drive)
      else $error("stored bit leaked onto a pin owned by the timer");
endmodule
`default_nettype wire

// file: core/dpp_port_regs.sv
// Top of the two-port data register block with its AXI4-Lite register slave
//
// Overview of operation
// - After power-on reset every pin of both ports is a general-purpose input.
// - The first port data register is 16 bits with only bits 3 and 2 writable.
// - A first-port output pin drives its stored bit, and reads return that bit.
// - A first-port input pin reads its live level; writes only update the stored bit.
// - Reset clears the first port data register; sleep leaves it untouched.
// - The second port data register has writable bits 14,13,12,7,6,5,4,2,0 only.
// - A second-port pin with direction zero reads its live level in either function.
// - A second-port output pin in general I/O drives and reads back its stored bit.
// - A second-port output pin owned by the timer reads the stored bit, drive unchanged.
// - Reset clears the second port data register; sleep leaves it untouched.
// - A direction bit of one makes the pin an output, zero an input; both reset zero.
// - Function-select zero means general I/O (reset), one hands the pin to the timer.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dpp_port_regs
   import dpp_pkg::*;
(
   input wire logic clk_sys_i, // 40 MHz system clock
   input wire logic reset_n_i, // Power-on reset, active low
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [15:0] p1_pin_in_i, // First port pin levels
   output logic [15:0] p1_pin_out_o, // First port drive values
   output logic [15:0] p1_pin_oe_n_o, // First port enables, low = driving
   input wire logic [15:0] p2_pin_in_i, // Second port pin levels
   output logic [15:0] p2_pin_out_o, // Second port drive values
   output logic [15:0] p2_pin_oe_n_o, // Second port enables, low = driving
   input wire logic [15:0] timer_drive_i, // Timer compare outputs for shared pins
   output logic [15:0] timer_level_o // Synchronised shared pin levels for capture
);
   // Merge strobed byte lanes of a write into a register, masked to its real bits
   function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
         input logic [31:0] wd, input logic [3:0] st, input logic [15:0] msk);
      logic [15:0] res;
      res = old_v;
      if (st[0]) begin
         res[7:0] = wd[7:0];
      end
      if (st[1]) begin
         res[15:8] = wd[15:8];
      end
      return res & msk;
   endfunction

   // Stored registers; only reset_n_i clears them, so sleep has no effect on them
   logic [15:0] p1_data_r;
   logic [15:0] p1_dir_r;
   logic [15:0] p2_data_r;
   logic [15:0] p2_dir_r;
   logic [15:0] p2_func_r;

   // Write channel holding registers
   logic aw_hold_r;
   logic [31:0] aw_addr_r;
   logic w_hold_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;

   // Read channel registers
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;

   wire [15:0] p1_read;
   wire [15:0] p2_read;
   wire [15:0] p1_level;
   wire [15:0] p2_level;

   // Write decode: fires once both halves are held and no response is pending
   wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
   wire wr_p1_data = do_write && (aw_addr_r == DPP_ADDR_P1_DATA);
   wire wr_p1_dir = do_write && (aw_addr_r == DPP_ADDR_P1_DIR);
   wire wr_p2_data = do_write && (aw_addr_r == DPP_ADDR_P2_DATA);
   wire wr_p2_dir = do_write && (aw_addr_r == DPP_ADDR_P2_DIR);
   wire wr_p2_func = do_write && (aw_addr_r == DPP_ADDR_P2_FUNC);
   wire wr_hit = wr_p1_data || wr_p1_dir || wr_p2_data || wr_p2_dir || wr_p2_func;

   // Read decode straight from the offered address
   wire ar_take = s_axi_arvalid && !rvalid_r;
   wire rd_p1_data = (s_axi_araddr == DPP_ADDR_P1_DATA);
   wire rd_p1_dir = (s_axi_araddr == DPP_ADDR_P1_DIR);
   wire rd_p2_data = (s_axi_araddr == DPP_ADDR_P2_DATA);
   wire rd_p2_dir = (s_axi_araddr == DPP_ADDR_P2_DIR);
   wire rd_p2_func = (s_axi_araddr == DPP_ADDR_P2_FUNC);
   wire rd_hit = rd_p1_data || rd_p1_dir || rd_p2_data || rd_p2_dir || rd_p2_func;
   wire [15:0] rd_val = ({16{rd_p1_data}} & p1_read) | ({16{rd_p1_dir}} & p1_dir_r)
      | ({16{rd_p2_data}} & p2_read) | ({16{rd_p2_dir}} & p2_dir_r)
      | ({16{rd_p2_func}} & p2_func_r);

   // Ready terms: one address and one data beat held at a time
   assign s_axi_awready = !aw_hold_r;
   assign s_axi_wready = !w_hold_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign timer_level_o = p2_level & DPP_P2_FUNC_MASK;

   // Address and data are caught independently, so either may arrive first
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= 32'h00000000;
         w_hold_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_hold_r) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_hold_r <= 1'b0;
         end
         if (s_axi_wvalid && !w_hold_r) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // Write response; an unmapped address still completes, with SLVERR
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bvalid_r <= 1'b0;
         bresp_r <= DPP_RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? DPP_RESP_OKAY : DPP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read answer is registered in the cycle the address is taken
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rvalid_r <= 1'b0;
         rresp_r <= DPP_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_hit ? DPP_RESP_OKAY : DPP_RESP_SLVERR;
         rdata_r <= {DPP_UPPER_ZERO, rd_val};
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Data registers: writes always store, whatever the pin direction or function
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p1_data_r <= DPP_DATA_RESET;
         p2_data_r <= DPP_DATA_RESET;
      end else begin
         if (wr_p1_data) begin
            p1_data_r <= lane_merge(p1_data_r, w_data_r, w_strb_r, DPP_P1_MASK);
         end
         if (wr_p2_data) begin
            p2_data_r <= lane_merge(p2_data_r, w_data_r, w_strb_r, DPP_P2_MASK);
         end
      end
   end

   // Direction and function-select registers; reset leaves all pins general inputs
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p1_dir_r <= DPP_DIR_RESET;
         p2_dir_r <= DPP_DIR_RESET;
         p2_func_r <= DPP_FUNC_RESET;
      end else begin
         if (wr_p1_dir) begin
            p1_dir_r <= lane_merge(p1_dir_r, w_data_r, w_strb_r, DPP_P1_MASK);
         end
         if (wr_p2_dir) begin
            p2_dir_r <= lane_merge(p2_dir_r, w_data_r, w_strb_r, DPP_P2_MASK);
         end
         if (wr_p2_func) begin
            p2_func_r <= lane_merge(p2_func_r, w_data_r, w_strb_r, DPP_P2_FUNC_MASK);
         end
      end
   end

   // First port has no alternate function, so its timer inputs stay idle
   dpp_pin_bank #(.MASK(DPP_P1_MASK)) u_p1_bank (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .data_i(p1_data_r),
      .dir_i(p1_dir_r),
      .alt_i(DPP_NO_PINS),
      .alt_out_i(DPP_NO_PINS),
      .pin_in_i(p1_pin_in_i),
      .pin_out_o(p1_pin_out_o),
      .pin_oe_n_o(p1_pin_oe_n_o),
      .level_o(p1_level),
      .read_o(p1_read)
   );

   // Second port hands selected pins to the timer
   dpp_pin_bank #(.MASK(DPP_P2_MASK)) u_p2_bank (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .data_i(p2_data_r),
      .dir_i(p2_dir_r),
      .alt_i(p2_func_r),
      .alt_out_i(timer_drive_i),
      .pin_in_i(p2_pin_in_i),
      .pin_out_o(p2_pin_out_o),
      .pin_oe_n_o(p2_pin_oe_n_o),
      .level_o(p2_level),
      .read_o(p2_read)
   );

   property p_p1_unused_zero;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (p1_data_r & ~DPP_P1_MASK) == 16'h0000;
   endproperty
   a_p1_unused_zero: assert property (p_p1_unused_zero)
      else $error("first port data holds an unimplemented bit");

   property p_p2_unused_zero;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (p2_data_r & ~DPP_P2_MASK) == 16'h0000 && (p2_func_r & ~DPP_P2_FUNC_MASK) == 16'h0000;
   endproperty
   a_p2_unused_zero: assert property (p_p2_unused_zero)
      else $error("second port register holds an unimplemented bit");

   property p_p1_read;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (ar_take && rd_p1_data) |=> s_axi_rdata == {16'h0000, (($past(p1_dir_r)
         & $past(p1_data_r)) | (~$past(p1_dir_r) & $past(p1_level))) & DPP_P1_MASK};
   endproperty
   a_p1_read: assert property (p_p1_read)
      else $error("first port read does not follow direction");

   property p_p2_read;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (ar_take && rd_p2_data) |=> s_axi_rvalid && s_axi_rdata[15:0] == ((($past(p2_dir_r)
         & $past(p2_data_r)) | (~$past(p2_dir_r) & $past(p2_level))) & DPP_P2_MASK);
   endproperty
   a_p2_read: assert property (p_p2_read)
      else $error("second port read does not follow direction");

   property p_p1_hold;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !wr_p1_data |=> $stable(p1_data_r);
   endproperty
   a_p1_hold: assert property (p_p1_hold)
      else $error("first port data changed without a write");

   property p_p2_hold;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !wr_p2_data |=> $stable(p2_data_r);
   endproperty
   a_p2_hold: assert property (p_p2_hold)
      else $error("second port data changed without a write");

   property p_byte_lane;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_p2_data && !w_strb_r[1]) |=> p2_data_r[15:8] == $past(p2_data_r[15:8]);
   endproperty
   a_byte_lane: assert property (p_byte_lane)
      else $error("unstrobed byte lane was written");

   property p_bresp_timing;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      do_write |=> s_axi_bvalid ##0 (s_axi_bresp == DPP_RESP_OKAY) == $past(wr_hit);
   endproperty
   a_bresp_timing: assert property (p_bresp_timing)
      else $error("write response late or wrong");
endmodule
`default_nettype wire

// file: sim/dpp_pin_model.sv
// Behavioural model of the board circuitry that drives or senses one port's pins
`timescale 1ns/1ps
`default_nettype none
module dpp_pin_model (
   input wire logic [15:0] pin_out_i, // Device drive values
   input wire logic [15:0] pin_oe_n_i, // Device enables, low = device drives
   input wire logic [15:0] ext_val_i, // Level the outside world applies
   input wire logic [15:0] ext_en_i, // 1 = outside world drives the pin
   output logic [15:0] level_o // Resolved pin level
);
   // Device wins where it drives; a released, undriven pin floats up to the pull-up level
   assign level_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_en_i & ext_val_i)
                    | (pin_oe_n_i & ~ext_en_i);
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the two-port data register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench
   import dpp_pkg::*;
;
   logic clk_sys_i, reset_n_i;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic [15:0] p1_in, p1_out, p1_oe_n, p2_in, p2_out, p2_oe_n, tmr_drv, tmr_lvl;
   logic [15:0] ext1_val, ext2_val, ext_en;
   int errors, checks;

   dpp_port_regs DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .p1_pin_in_i(p1_in), .p1_pin_out_o(p1_out), .p1_pin_oe_n_o(p1_oe_n),
      .p2_pin_in_i(p2_in), .p2_pin_out_o(p2_out), .p2_pin_oe_n_o(p2_oe_n),
      .timer_drive_i(tmr_drv), .timer_level_o(tmr_lvl));
   dpp_pin_model pins1 (.pin_out_i(p1_out), .pin_oe_n_i(p1_oe_n), .ext_val_i(ext1_val),
      .ext_en_i(ext_en), .level_o(p1_in));
   dpp_pin_model pins2 (.pin_out_i(p2_out), .pin_oe_n_i(p2_oe_n), .ext_val_i(ext2_val),
      .ext_en_i(ext_en), .level_o(p2_in));

   // 40 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask

   // Handshakes are judged at the falling edge, which sees what the next rising edge samples
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] er = DPP_RESP_OKAY);
      logic ta, tw, tb;
      logic [1:0] rs;
      int n;
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      n = 0;
      while (!tb && n < 50) begin
         @(negedge clk_sys_i);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         rs = bresp;
         @(posedge clk_sys_i);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      `CHK({tb, rs}, {1'b1, er})
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] ed,
                     input logic [1:0] er = DPP_RESP_OKAY);
      logic ta, tr;
      logic [1:0] rs;
      logic [31:0] d;
      int n;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      n = 0;
      while (!tr && n < 50) begin
         @(negedge clk_sys_i);
         ta = arvalid && arready;
         tr = rvalid && rready;
         d = rdata;
         rs = rresp;
         @(posedge clk_sys_i);
         if (ta) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      `CHK({tr, rs, d}, {1'b1, er, ed})
   endtask

   // Stored data is only visible through outputs, so both ports are turned to drive first
   task automatic reset_values;
      wr(DPP_ADDR_P1_DIR, 32'h0000FFFF);
      wr(DPP_ADDR_P2_DIR, 32'h0000FFFF);
      rd(DPP_ADDR_P1_DATA, 32'h00000000);
      rd(DPP_ADDR_P2_DATA, 32'h00000000);
   endtask

   task automatic end_sim;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under two thousand cycles
   initial begin
      tick(20000);
      errors++;
      end_sim;
   end

   initial begin
      errors = 0;
      checks = 0;
      reset_n_i = 1'b0;
      {awaddr, wdata, araddr, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {tmr_drv, ext1_val, ext2_val} = '0;
      ext_en = 16'hFFFF;
      tick(16);
      reset_n_i <= 1'b1;
      // Pins are looked at mid-cycle, away from the edge that launches them
      @(negedge clk_sys_i);
      `CHK({p1_oe_n, p2_oe_n}, {16'hFFFF, 16'hFFFF})
      rd(DPP_ADDR_P1_DIR, 32'h00000000);
      rd(DPP_ADDR_P2_DIR, 32'h00000000);
      rd(DPP_ADDR_P2_FUNC, 32'h00000000);
      reset_values();
      // Masks and general-purpose output drive
      wr(DPP_ADDR_P1_DATA, 32'hFFFFFFFF);
      wr(DPP_ADDR_P2_DATA, 32'hFFFFFFFF);
      rd(DPP_ADDR_P1_DATA, 32'h0000000C);
      rd(DPP_ADDR_P2_DATA, 32'h000070F5);
      @(negedge clk_sys_i);
      `CHK({p1_out, p1_oe_n}, {16'h000C, 16'hFFF3})
      `CHK({p2_out, p2_oe_n}, {16'h70F5, 16'h8F0A})
      // First port as input: live level read, writes stored but not driven
      wr(DPP_ADDR_P1_DIR, 32'h00000000);
      ext1_val <= 16'h0004;
      tick(4);
      rd(DPP_ADDR_P1_DATA, 32'h00000004);
      wr(DPP_ADDR_P1_DATA, 32'h00000000);
      @(negedge clk_sys_i);
      `CHK(p1_oe_n, 16'hFFFF)
      ext_en <= 16'hFFF3;
      tick(4);
      rd(DPP_ADDR_P1_DATA, 32'h0000000C);
      ext_en <= 16'hFFFF;
      wr(DPP_ADDR_P1_DIR, 32'h0000FFFF);
      rd(DPP_ADDR_P1_DATA, 32'h00000000);
      // Shared pins handed to the timer while outputs
      wr(DPP_ADDR_P2_FUNC, 32'h0000FFFF);
      rd(DPP_ADDR_P2_FUNC, 32'h000000F5);
      tmr_drv <= 16'h00A0;
      tick(1);
      @(negedge clk_sys_i);
      `CHK(p2_out, 16'h70A0)
      wr(DPP_ADDR_P2_DATA, 32'h00000000);
      @(negedge clk_sys_i);
      `CHK({p2_out, p2_oe_n}, {16'h00A0, 16'h8F0A})
      rd(DPP_ADDR_P2_DATA, 32'h00000000);
      tick(2);
      @(negedge clk_sys_i);
      `CHK(tmr_lvl, 16'h00A0)
      // Second port as input reads live levels in either function
      wr(DPP_ADDR_P2_DIR, 32'h00000000);
      ext2_val <= 16'h5A5A;
      tick(4);
      rd(DPP_ADDR_P2_DATA, 32'h00005050);
      @(negedge clk_sys_i);
      `CHK(p2_oe_n, 16'hFFFF)
      `CHK(tmr_lvl, 16'h0050)
      wr(DPP_ADDR_P2_FUNC, 32'h00000000);
      rd(DPP_ADDR_P2_DATA, 32'h00005050);
      // Byte lanes update alone; upper strobes touch nothing
      wr(DPP_ADDR_P2_DIR, 32'h0000FFFF);
      wr(DPP_ADDR_P2_DATA, 32'hFFFFFFFF, 4'h2);
      rd(DPP_ADDR_P2_DATA, 32'h00007000);
      wr(DPP_ADDR_P2_DATA, 32'hFFFFFFFF, 4'h1);
      wr(DPP_ADDR_P2_DATA, 32'h00000000, 4'hC);
      rd(DPP_ADDR_P2_DATA, 32'h000070F5);
      // Unmapped place answers with an error and no data
      wr(32'hFFFF8388, 32'hFFFFFFFF, 4'hF, DPP_RESP_SLVERR);
      rd(32'hFFFF8388, 32'h00000000, DPP_RESP_SLVERR);
      // Reset in mid-run clears stored data and releases every pin
      @(posedge clk_sys_i);
      reset_n_i <= 1'b0;
      tick(3);
      reset_n_i <= 1'b1;
      @(negedge clk_sys_i);
      `CHK({p1_oe_n, p2_oe_n}, {16'hFFFF, 16'hFFFF})
      reset_values();
      end_sim;
   end
endmodule
`default_nettype wire
